// ### rtl/pwc_ctrl.sv
// PWM period, interrupt, fault suppression and output stage
//
// Register access over Wishbone and the address map are this design's own decisions.
`default_nettype none
module pwc_ctrl #(
  parameter int NGEN = 4,
  parameter int PW = 16
) (
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [3:0] fault_in, // Fault pins, asynchronous
  input wire logic [2*NGEN-1:0] pwm_raw, // Generated waveforms
  input wire logic [NGEN-1:0] cmp_a_hit, // Comparator A match
  input wire logic [NGEN-1:0] cmp_b_hit, // Comparator B match
  output logic [2*NGEN-1:0] pwm_out, // Final outputs
  output logic [NGEN-1:0] count_zero, // Zero-count pulses
  output logic [NGEN-1:0] adc_trig, // Trigger pulses
  output logic irq // Level interrupt
);
  // Local copy of the event count, keeps field slices short
  localparam int EVT_BITS = pwc_pkg::EVT_BITS;

  // Overview of the data flow
  // Bus writes land only at the edge that carries the ack
  // Reads are latched one edge early, then held for the master
  // Fault pins pass two flops, then sense and enable masks
  // Each generator runs an up/down counter in PWM ticks
  // Zero pulse opens every period, peak pulse is the load event
  // Events feed sticky status and the trigger outputs
  // Module status folds generator status with fault edges
  // Output stage: suppress, optional level, then inversion
  // Limitation: periods below three ticks are not supported
  // Limitation: fault sources are shared by all generators
  // Trade-off: generator status lags events by one clock, module status by two, no comb path
  // Hazard: clock enable low freezes counters and the bus
  logic [3:0] f_s1_r, f_s2_r;
  logic [31:0] ctrl_r, inten_r, ris_r, supp_r, flvl_r, inv_r, src_r;
  logic [PW-1:0] per_prog_r [NGEN];
  logic [PW-1:0] per_act_r [NGEN];
  logic [PW-1:0] cnt_r [NGEN];
  logic [NGEN-1:0] dir_r;
  logic [15:0] inttrig_r [NGEN];
  logic [EVT_BITS-1:0] gris_r [NGEN];
  logic [EVT_BITS-1:0] evt [NGEN];
  logic [NGEN-1:0] load_pulse;
  logic [NGEN-1:0] gfault;
  logic [3:0] fault_evt;
  logic [3:0] f_prev_r;
  logic [7:0] mis;
  logic wr, rd_en;
  logic [31:0] rdata_nxt;

  // Byte-lane merge, used by every configuration register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        merge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction

  // Generator register address test
  function automatic logic gen_hit(input logic [7:0] a, input int g, input logic [3:0] o);
    gen_hit = (a == (pwc_pkg::OFS_GEN_BASE + 8'(g * 16) + {4'h0, o}));
  endfunction

  // Peak count, half the period; odd periods add a tick at zero
  function automatic logic [PW-1:0] half_per(input logic [PW-1:0] p);
    half_per = p >> 1;
  endfunction

  // Write lands at the ack edge, while the master still holds it
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && ce;
  // Request taken one edge before the ack
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;

  // Fault pin synchroniser, two stages before any use
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      f_s1_r <= 4'h0;
      f_s2_r <= 4'h0;
      f_prev_r <= 4'h0;
    end
    else if (ce)
    begin
      f_s1_r <= fault_in;
      f_s2_r <= f_s1_r;
      f_prev_r <= f_s2_r;
    end
  end

  // Rising edge of a synchronised, sense-adjusted fault
  assign fault_evt = (f_s2_r ^ src_r[3:0]) & ~(f_prev_r ^ src_r[3:0]);

  // Module-level configuration registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= pwc_pkg::ZERO_RST;
      inten_r <= pwc_pkg::ZERO_RST;
      supp_r <= pwc_pkg::ZERO_RST;
      flvl_r <= pwc_pkg::ZERO_RST;
      inv_r <= pwc_pkg::ZERO_RST;
      src_r <= pwc_pkg::SRC_RST;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        pwc_pkg::OFS_CTRL: ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0003;
        pwc_pkg::OFS_INTEN: inten_r <= merge(inten_r, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        pwc_pkg::OFS_SUPP: supp_r <= merge(supp_r, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        pwc_pkg::OFS_FLVL: flvl_r <= merge(flvl_r, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        pwc_pkg::OFS_INV: inv_r <= merge(inv_r, wb_dat_i, wb_sel_i) & 32'h0000_00FF;
        pwc_pkg::OFS_FAULT_SRC: src_r <= merge(src_r, wb_dat_i, wb_sel_i) & 32'h000F_000F;
        default: ;
      endcase
    end
  end

  // Per-generator counters, period and events
  for (genvar g = 0; g < NGEN; g++)
  begin : gen_g
    // OR of enabled sensed fault sources
    assign gfault[g] = |((f_s2_r ^ src_r[3:0]) & src_r[pwc_pkg::FAULT_SHIFT +: 4]);
    // Load event at the peak, first tick of the down slope
    assign load_pulse[g] = (cnt_r[g] == half_per(per_act_r[g])) && !dir_r[g];
    assign count_zero[g] = (cnt_r[g] == '0) && !dir_r[g] && ce;
    assign evt[g] = {cmp_b_hit[g] && !dir_r[g], cmp_b_hit[g] && dir_r[g],
                     cmp_a_hit[g] && !dir_r[g], cmp_a_hit[g] && dir_r[g],
                     load_pulse[g], count_zero[g]};
    assign adc_trig[g] = |(evt[g] & inttrig_r[g][pwc_pkg::TRIG_SHIFT +: EVT_BITS]) && ce;

    // Programmed period; last write wins
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        per_prog_r[g] <= pwc_pkg::PERIOD_RST;
      else if (wr && gen_hit(wb_adr_i, g, pwc_pkg::GOFS_PERIOD))
        per_prog_r[g] <= PW'(merge(32'(per_prog_r[g]), wb_dat_i, wb_sel_i));
    end

    // Active period taken at zero so a period never tears
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        per_act_r[g] <= pwc_pkg::PERIOD_RST;
      else if (count_zero[g])
        per_act_r[g] <= per_prog_r[g];
    end

    // Up/down counter, zero pulse once per period
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        cnt_r[g] <= '0;
        dir_r[g] <= 1'b1;
      end
      else if (ce)
      begin
        // up H, down H, plus one tick if odd
        if (dir_r[g] && cnt_r[g] + PW'(1) >= half_per(per_act_r[g]))
        begin
          cnt_r[g] <= cnt_r[g] + PW'(1);
          dir_r[g] <= 1'b0;
        end
        // Zero: new period taken now, so its parity decides
        else if (!dir_r[g] && cnt_r[g] == '0)
        begin
          cnt_r[g] <= per_prog_r[g][0] ? '0 : PW'(1);
          dir_r[g] <= 1'b1;
        end
        else if (dir_r[g])
          cnt_r[g] <= cnt_r[g] + PW'(1);
        else
          cnt_r[g] <= cnt_r[g] - PW'(1);
      end
    end

    // Interrupt and trigger enable register
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        inttrig_r[g] <= 16'h0000;
      else if (wr && gen_hit(wb_adr_i, g, pwc_pkg::GOFS_INTTRIG))
        inttrig_r[g] <= 16'(merge(32'(inttrig_r[g]), wb_dat_i, wb_sel_i)) & 16'h3F3F;
    end

    // Generator status, set beats clear
    always_ff @(posedge clk)
    begin
      if (!reset_n)
        gris_r[g] <= '0;
      else if (ce)
      begin
        // write one to clear, new event wins
        if (wr && gen_hit(wb_adr_i, g, pwc_pkg::GOFS_GISC) && wb_sel_i[0])
          gris_r[g] <= (gris_r[g] & ~wb_dat_i[EVT_BITS-1:0]) | evt[g];
        else
          gris_r[g] <= gris_r[g] | evt[g];
      end
    end
  end

  // Module raw status: generators in low nibble, faults high
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ris_r <= pwc_pkg::ZERO_RST;
    else if (ce)
    begin
      for (int g = 0; g < NGEN; g++)
      begin
        if (|(gris_r[g] & inttrig_r[g][EVT_BITS-1:0]))
          ris_r[g] <= 1'b1;
        else
          ris_r[g] <= 1'b0;
      end
      for (int f = 0; f < 4; f++)
      begin
        // Sticky fault bits; a clear in the event cycle loses
        if (fault_evt[f])
          ris_r[4+f] <= 1'b1;
        else if (wr && wb_adr_i == pwc_pkg::OFS_ISC && wb_sel_i[0] && wb_dat_i[4+f])
          ris_r[4+f] <= 1'b0;
      end
    end
  end

  assign mis = ris_r[7:0] & inten_r[7:0];
  assign irq = |mis;

  // Output stage: suppress, level, invert
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pwm_out <= '0;
    else if (ce)
    begin
      for (int o = 0; o < 2*NGEN; o++)
      begin
        logic v;
        v = pwm_raw[o];
        if (gfault[o/2] && supp_r[o])
          v = ctrl_r[pwc_pkg::CTRL_EXT_BIT] && ctrl_r[pwc_pkg::CTRL_LVLV_BIT] && flvl_r[o];
        pwm_out[o] <= v ^ inv_r[o];
      end
    end
  end

  // Read mux
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      pwc_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
      pwc_pkg::OFS_INTEN: rdata_nxt = inten_r;
      pwc_pkg::OFS_RIS: rdata_nxt = {24'h0, ris_r[7:0]};
      pwc_pkg::OFS_ISC: rdata_nxt = {24'h0, mis};
      pwc_pkg::OFS_SUPP: rdata_nxt = supp_r;
      pwc_pkg::OFS_FLVL: rdata_nxt = flvl_r;
      pwc_pkg::OFS_INV: rdata_nxt = inv_r;
      pwc_pkg::OFS_FAULT_SRC: rdata_nxt = src_r;
      default: ;
    endcase
    for (int g = 0; g < NGEN; g++)
    begin
      if (gen_hit(wb_adr_i, g, pwc_pkg::GOFS_PERIOD))
        rdata_nxt = 32'(per_prog_r[g]);
      if (gen_hit(wb_adr_i, g, pwc_pkg::GOFS_INTTRIG))
        rdata_nxt = 32'(inttrig_r[g]);
      if (gen_hit(wb_adr_i, g, pwc_pkg::GOFS_GRIS))
        rdata_nxt = 32'(gris_r[g]);
      if (gen_hit(wb_adr_i, g, pwc_pkg::GOFS_GISC))
        rdata_nxt = 32'(gris_r[g] & inttrig_r[g][EVT_BITS-1:0]);
    end
  end

  // One-wait-state ack, dropped the cycle after
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= rd_en;
      // Writes leave the read data alone so it holds until a read
      if (rd_en && !wb_we_i)
        wb_dat_o <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ### rtl/pwc_pkg.sv
// Package of constants for the PWM control block
// What this block does
// - Per-generator interrupt and trigger enable register
// - Period equals ticks between zero pulses
// - Period read returns last written value
// - Later period writes replace pending ones
// - Module enable: four generator, four fault bits
// - Clearing enable bits masks only those
// - Raw and masked module status views
// - Suppressed outputs forced during fault
// - Unsuppressed outputs follow waveform during fault
// - Suppressed level low by default
// - Fault level high drives suppressed high when both control bits are set
// - Fault level ignored without suppression
// - Per-output inversion makes output active low
// - Generator fault is OR of enabled sources
// - Status bits cleared by writing ones
`default_nettype none
package pwc_pkg;
  // Register byte offsets, generator blocks at 0x40 + 0x10 * g
  localparam logic [7:0] OFS_CTRL = 8'h00;     // extended fault, fault-level valid
  localparam logic [7:0] OFS_INTEN = 8'h04;    // module interrupt enable
  localparam logic [7:0] OFS_RIS = 8'h08;      // raw status (read)
  localparam logic [7:0] OFS_ISC = 8'h0C;      // masked status read, write one to clear fault bits
  localparam logic [7:0] OFS_SUPP = 8'h10;     // fault suppress per output
  localparam logic [7:0] OFS_FLVL = 8'h14;     // fault level per output
  localparam logic [7:0] OFS_INV = 8'h18;      // inversion per output
  localparam logic [7:0] OFS_FAULT_SRC = 8'h1C; // fault sense and enables
  localparam logic [7:0] OFS_GEN_BASE = 8'h40;
  localparam logic [3:0] GOFS_PERIOD = 4'h0;
  localparam logic [3:0] GOFS_INTTRIG = 4'h4;
  localparam logic [3:0] GOFS_GRIS = 4'h8;
  localparam logic [3:0] GOFS_GISC = 4'hC;
  // Field positions of the generator enable, fault source and control registers
  localparam int TRIG_SHIFT = 8;
  localparam int EVT_BITS = 6;
  localparam int FAULT_SHIFT = 16;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_LVLV_BIT = 1;
  // Reset values
  localparam logic [15:0] PERIOD_RST = 16'h0100;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] SRC_RST = 32'h0001_0000;
endpackage
`default_nettype wire

// ### verification/pwc_ctrl_sva.sv
// Checker of bus, reset and zero-pulse timing for the PWM control block
`default_nettype none
module pwc_ctrl_sva #(
  parameter int NGEN = 4,
  parameter int PW = 16
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic ce, // Enable
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic [2*NGEN-1:0] pwm_out, // Outputs
  input wire logic [NGEN-1:0] count_zero, // Zero pulses
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Request taken at an edge
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  // Ack is one pulse, one cycle after the request
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> s_ack) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack idle");
  // Read data only moves after a read
  a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_irq_reset: assert property ($rose(reset_n) |-> !irq) else $error("irq after reset");
  a_out_reset: assert property ($rose(reset_n) |-> pwm_out == '0 && !wb_ack_o) else $error("out after reset");
  // Zero event is a pulse that recurs; bound covers the longest period used
  a_zero_pulse: assert property (count_zero[0] |=> !count_zero[0]) else $error("zero too long");
  a_zero_recur: assert property (count_zero[0] |-> ##[2:600] count_zero[0]) else $error("zero lost");
endmodule
bind pwc_ctrl pwc_ctrl_sva #(.NGEN(NGEN), .PW(PW)) pwc_ctrl_sva_inst (.clk(clk), .reset_n(reset_n), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pwm_out(pwm_out), .count_zero(count_zero), .irq(irq));
`default_nettype wire

// ### verification/pwc_ctrl_tb.sv
// Self-checking bench for the PWM control block
`default_nettype none
module pwc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] fault_in = 4'h0;
  logic [7:0] raw = 8'h00;
  logic [3:0] cmp_a = 4'h0;
  logic [3:0] cmp_b = 4'h0;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [7:0] pwm_out;
  logic [3:0] count_zero;
  logic [3:0] adc_trig;
  logic [31:0] lfsr = 32'h0000_0C75;
  logic [31:0] q;
  logic [31:0] src_m;
  logic [1:0] ctl_m;
  logic f_m;
  int fails = 0;
  int tests_run = 0;
  int n;
  pwc_ctrl pwc_ctrl_inst (.clk(clk), .reset_n(reset_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .fault_in(fault_in),
    .pwm_raw(raw), .cmp_a_hit(cmp_a), .cmp_b_hit(cmp_b), .pwm_out(pwm_out), .count_zero(count_zero),
    .adc_trig(adc_trig), .irq(irq));
  // Free-running 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // Helpers: random source, generator address, output model
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ga(input int g, input logic [3:0] o);
    return 8'(pwc_pkg::OFS_GEN_BASE + 16 * g + o);
  endfunction
  // Suppress 0F, level 05, invert 30; level counts only with both control bits
  function automatic logic [31:0] exp_out(input logic [7:0] r, input logic f, input logic [1:0] c);
    return 32'(((r & ~(f ? 8'h0F : 8'h00)) | ((f && c == 2'h3) ? 8'h05 : 8'h00)) ^ 8'h30);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A used-up wait counts as a mismatch and ends the run
  task automatic limit(input int k, input int m);
    if (k >= m)
    begin
      fails++;
      finish_test();
    end
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    limit(k, 50);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Cycles until the next zero pulse of generator g
  task automatic wait_zero(input int g);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (count_zero[g] !== 1'b1 && n < 2000);
    limit(n, 2000);
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(ga(0, pwc_pkg::GOFS_PERIOD), 32'(pwc_pkg::PERIOD_RST), "period0");
    rd(pwc_pkg::OFS_FAULT_SRC, pwc_pkg::SRC_RST, "src");
    rd(8'hF0, 32'h0, "unmapped");
    wb(1'b1, ga(1, pwc_pkg::GOFS_PERIOD), 32'h20);
    wb(1'b1, ga(1, pwc_pkg::GOFS_PERIOD), 32'h10);
    rd(ga(1, pwc_pkg::GOFS_PERIOD), 32'h10, "period1");
    wait_zero(1);
    wait_zero(1);
    wait_zero(1);
    chk("spacing", 32'h10, n);
    wb(1'b1, ga(0, pwc_pkg::GOFS_INTTRIG), 32'h101);
    wb(1'b1, pwc_pkg::OFS_INTEN, 32'h11);
    wait_zero(0);
    chk("trig0", 32'h1, adc_trig[0]);
    repeat (3) @(posedge clk);
    chk("irq_on", 32'h1, irq);
    rd(pwc_pkg::OFS_ISC, 32'h1, "masked");
    wb(1'b1, pwc_pkg::OFS_INTEN, 32'h10);
    rd(pwc_pkg::OFS_INTEN, 32'h10, "inten");
    rd(pwc_pkg::OFS_ISC, 32'h0, "masked_off");
    chk("irq_off", 32'h0, irq);
    rd(pwc_pkg::OFS_RIS, 32'h1, "raw");
    wb(1'b1, ga(0, pwc_pkg::GOFS_GISC), 32'h1);
    repeat (2) @(posedge clk);
    rd(pwc_pkg::OFS_RIS, 32'h0, "raw_clr");
    wb(1'b1, pwc_pkg::OFS_SUPP, 32'h0F);
    wb(1'b1, pwc_pkg::OFS_FLVL, 32'h05);
    wb(1'b1, pwc_pkg::OFS_INV, 32'h30);
    // Every control setting, both source configs, fault on and off
    for (int i = 0; i < 8; i++)
    begin
      ctl_m = 2'(i % 4);
      src_m = i[2] ? 32'h0002_0002 : pwc_pkg::SRC_RST;
      wb(1'b1, pwc_pkg::OFS_CTRL, 32'(ctl_m));
      wb(1'b1, pwc_pkg::OFS_FAULT_SRC, src_m);
      lfsr = next_rand(lfsr);
      fault_in <= {lfsr[3:2], i[1], i[1]};
      repeat (4) @(posedge clk);
      f_m = |((fault_in ^ src_m[3:0]) & src_m[19:16]);
      repeat (4)
      begin
        lfsr = next_rand(lfsr);
        raw <= lfsr[7:0];
        cmp_a <= lfsr[11:8];
        cmp_b <= lfsr[15:12];
        repeat (2) @(posedge clk);
        chk("pwm_out", exp_out(raw, f_m, ctl_m), pwm_out);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
